// ---- hw/pin_routing_pkg.sv ----
// Constants shared by the audio port pin routing block
package pin_routing_pkg;
    // Register offsets
    localparam logic [7:0] DATA_OUT_PIN_CONFIG_OFFSET = 8'h10;
    localparam logic [7:0] SECONDARY_PORT_CLOCK_SOURCE_OFFSET = 8'h11;
    localparam logic [7:0] SECONDARY_PORT_INPUT_SOURCE_OFFSET = 8'h12;
    localparam logic [7:0] PIN_FUNCTION_ROUTING_OFFSET = 8'h14;
    // Reset values
    localparam logic [7:0] DATA_OUT_PIN_CONFIG_RESET = 8'h52;
    localparam logic [7:0] SECONDARY_PORT_CLOCK_SOURCE_RESET = 8'h80;
    localparam logic [7:0] SECONDARY_PORT_INPUT_SOURCE_RESET = 8'h00;
    localparam logic [7:0] PIN_FUNCTION_ROUTING_RESET = 8'h00;
    // Read-only reserved bits are held at zero by these write masks
    localparam logic [7:0] CLOCK_SOURCE_WRITE_MASK = 8'hfe;
    localparam logic [7:0] INPUT_SOURCE_WRITE_MASK = 8'hfc;
    // Field positions
    localparam int OUT_PIN_FUNCTION_LSB = 4;
    localparam int OUT_PIN_LEVEL_BIT = 3;
    localparam int OUT_PIN_DRIVE_STYLE_LSB = 0;
    localparam int PRIMARY_INPUT_ENABLE_BIT = 7;
    localparam int SECONDARY_FRAME_SOURCE_LSB = 4;
    localparam int SECONDARY_BITCLOCK_SOURCE_LSB = 1;
    localparam int SECONDARY_INPUT_SOURCE_LSB = 5;
    localparam int SECONDARY_INPUT2_SOURCE_LSB = 2;
    localparam int PIN_DAC_POWERDOWN_SOURCE_LSB = 2;
    localparam int POWER_LIMIT_PIN_ROUTE_BIT = 1;
    localparam int GAIN_ADJUST_PIN_ROUTE_BIT = 0;
    // Data-out pin function codes
    localparam logic [3:0] FN_DISABLED = 4'h0;
    localparam logic [3:0] FN_INPUT = 4'h1;
    localparam logic [3:0] FN_GENERAL_OUTPUT = 4'h2;
    localparam logic [3:0] FN_INTERRUPT = 4'h3;
    localparam logic [3:0] FN_PDM_CLOCK = 4'h4;
    localparam logic [3:0] FN_PRIMARY_DATA = 4'h5;
    localparam logic [3:0] FN_PRIMARY_DATA2 = 4'h6;
    localparam logic [3:0] FN_SECONDARY_DATA = 4'h7;
    localparam logic [3:0] FN_SECONDARY_DATA2 = 4'h8;
    localparam logic [3:0] FN_SECONDARY_BITCLOCK = 4'h9;
    localparam logic [3:0] FN_SECONDARY_FRAME = 4'ha;
    localparam logic [3:0] FN_GENERAL_CLOCK = 4'hb;
    localparam logic [3:0] FN_MUXED_DATA = 4'hc;
    localparam logic [3:0] FN_DAISY_OUT = 4'hd;
    localparam logic [3:0] FN_LOOPBACK = 4'he;
    localparam logic [3:0] FN_RESERVED = 4'hf;
    // Drive style codes
    localparam logic [2:0] DRV_HIZ = 3'h0;
    localparam logic [2:0] DRV_ACTIVE_BOTH = 3'h1;
    localparam logic [2:0] DRV_WEAK_HIGH = 3'h2;
    localparam logic [2:0] DRV_HIZ_HIGH = 3'h3;
    localparam logic [2:0] DRV_WEAK_LOW = 3'h4;
    localparam logic [2:0] DRV_HIZ_LOW = 3'h5;
    // Source-select codes
    localparam logic [2:0] SRC_OFF = 3'h0;
    localparam logic [2:0] SRC_GENERAL_PIN_ONE = 3'h1;
    localparam logic [2:0] SRC_GENERAL_PIN_TWO = 3'h2;
    localparam logic [2:0] SRC_INPUT_ONLY_PIN = 3'h3;
    localparam logic [2:0] SRC_OUT_PIN = 3'h4;
    localparam logic [2:0] SRC_PRIMARY = 3'h5;
endpackage : pin_routing_pkg

// ---- hw/source_select.sv ----
// One source-select multiplexer for a routed internal signal
`timescale 1ns/10ps
module source_select #(
    parameter bit ALLOW_OUT_PIN = 1'b0
) (
    input wire logic [2:0] code,
    input wire logic general_pin_one,
    input wire logic general_pin_two,
    input wire logic input_only_pin,
    input wire logic out_pin,
    input wire logic primary,
    output logic selected,
    output logic valid
);
    import pin_routing_pkg::*;

    // Reserved codes fall to the inactive level, like code zero
    always_comb begin
        selected = 1'b0;
        valid = 1'b1;
        case (code)
            SRC_GENERAL_PIN_ONE: selected = general_pin_one;
            SRC_GENERAL_PIN_TWO: selected = general_pin_two;
            SRC_INPUT_ONLY_PIN: selected = input_only_pin;
            SRC_OUT_PIN: begin
                selected = ALLOW_OUT_PIN ? out_pin : 1'b0;
                valid = ALLOW_OUT_PIN;
            end
            SRC_PRIMARY: selected = primary;
            default: valid = 1'b0;
        endcase
    end
endmodule : source_select

// ---- hw/audio_port_pin_routing.sv ----
// Pin multiplexing and routing for the audio serial ports and data-out pin
`timescale 1ns/10ps
module audio_port_pin_routing (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic general_pin_one,
    input wire logic general_pin_two,
    input wire logic input_only_pin,
    input wire logic out_pin_in,
    output logic out_pin_out,
    output logic out_pin_oe,
    output logic out_pin_pullup,
    output logic out_pin_pulldown,
    output logic out_pin_as_input,
    input wire logic irq_in,
    input wire logic pdm_clock_output,
    input wire logic primary_data_out,
    input wire logic primary_data2_out,
    input wire logic secondary_data_out,
    input wire logic secondary_data2_out,
    input wire logic secondary_bitclock_out,
    input wire logic secondary_frame_out,
    input wire logic general_clock_output,
    input wire logic muxed_data_out,
    input wire logic daisy_out,
    input wire logic primary_frame_in,
    input wire logic primary_bitclock_in,
    input wire logic primary_data_in,
    input wire logic register_dac_powerdown,
    output logic primary_data,
    output logic secondary_frame,
    output logic secondary_bitclock,
    output logic secondary_data,
    output logic secondary_data2,
    output logic secondary_port_enable,
    output logic dac_powerdown,
    output logic power_limit_function,
    output logic gain_adjust_function
);
    import pin_routing_pkg::*;

    logic [7:0] data_out_pin_config_reg, data_out_pin_config_next;
    logic [7:0] secondary_port_clock_source_reg, secondary_port_clock_source_next;
    logic [7:0] secondary_port_input_source_reg, secondary_port_input_source_next;
    logic [7:0] pin_function_routing_reg, pin_function_routing_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [3:0] out_pin_function;
    logic out_pin_level;
    logic [2:0] out_pin_drive_style;
    logic primary_input_enable;
    logic [2:0] secondary_frame_source, secondary_bitclock_source;
    logic [2:0] secondary_input_source, secondary_input2_source;
    logic [1:0] pin_dac_powerdown_source;
    logic power_limit_pin_route, gain_adjust_pin_route;
    logic frame_sel, frame_valid, bitclock_sel, bitclock_valid;
    logic input_sel, input2_sel, powerdown_sel;
    logic pin_value, pin_driven, pin_as_input;
    logic out_reg, oe_reg, pullup_reg, pulldown_reg, as_input_reg;
    logic out_next, oe_next, pullup_next, pulldown_next;
    logic primary_reg, frame_reg, bitclock_reg, data_reg, data2_reg, enable_reg;
    logic powerdown_reg, power_limit_function_reg, gain_reg;

    // Field views of the configuration registers
    assign out_pin_function = data_out_pin_config_reg[OUT_PIN_FUNCTION_LSB +: 4];
    assign out_pin_level = data_out_pin_config_reg[OUT_PIN_LEVEL_BIT];
    assign out_pin_drive_style = data_out_pin_config_reg[OUT_PIN_DRIVE_STYLE_LSB +: 3];
    assign primary_input_enable = secondary_port_clock_source_reg[PRIMARY_INPUT_ENABLE_BIT];
    assign secondary_frame_source = secondary_port_clock_source_reg[SECONDARY_FRAME_SOURCE_LSB +: 3];
    assign secondary_bitclock_source = secondary_port_clock_source_reg[SECONDARY_BITCLOCK_SOURCE_LSB +: 3];
    assign secondary_input_source = secondary_port_input_source_reg[SECONDARY_INPUT_SOURCE_LSB +: 3];
    assign secondary_input2_source = secondary_port_input_source_reg[SECONDARY_INPUT2_SOURCE_LSB +: 3];
    assign pin_dac_powerdown_source = pin_function_routing_reg[PIN_DAC_POWERDOWN_SOURCE_LSB +: 2];
    assign power_limit_pin_route = pin_function_routing_reg[POWER_LIMIT_PIN_ROUTE_BIT];
    assign gain_adjust_pin_route = pin_function_routing_reg[GAIN_ADJUST_PIN_ROUTE_BIT];

    // Register writes and reads; read-only reserved bits are masked to zero
    always_comb begin
        data_out_pin_config_next = data_out_pin_config_reg;
        secondary_port_clock_source_next = secondary_port_clock_source_reg;
        secondary_port_input_source_next = secondary_port_input_source_reg;
        pin_function_routing_next = pin_function_routing_reg;
        rdata_next = rdata_reg;
        if (reg_wr) begin
            case (reg_addr)
                DATA_OUT_PIN_CONFIG_OFFSET: data_out_pin_config_next = reg_wdata;
                SECONDARY_PORT_CLOCK_SOURCE_OFFSET: begin
                    secondary_port_clock_source_next = reg_wdata & CLOCK_SOURCE_WRITE_MASK;
                end
                SECONDARY_PORT_INPUT_SOURCE_OFFSET: begin
                    secondary_port_input_source_next = reg_wdata & INPUT_SOURCE_WRITE_MASK;
                end
                PIN_FUNCTION_ROUTING_OFFSET: pin_function_routing_next = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                DATA_OUT_PIN_CONFIG_OFFSET: rdata_next = data_out_pin_config_reg;
                SECONDARY_PORT_CLOCK_SOURCE_OFFSET: rdata_next = secondary_port_clock_source_reg;
                SECONDARY_PORT_INPUT_SOURCE_OFFSET: rdata_next = secondary_port_input_source_reg;
                PIN_FUNCTION_ROUTING_OFFSET: rdata_next = pin_function_routing_reg;
                default: rdata_next = 8'h00; // Unmapped offsets read as zero
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_out_pin_config_reg <= DATA_OUT_PIN_CONFIG_RESET;
            secondary_port_clock_source_reg <= SECONDARY_PORT_CLOCK_SOURCE_RESET;
            secondary_port_input_source_reg <= SECONDARY_PORT_INPUT_SOURCE_RESET;
            pin_function_routing_reg <= PIN_FUNCTION_ROUTING_RESET;
            rdata_reg <= 8'h00;
        end else if (clk_en) begin
            data_out_pin_config_reg <= data_out_pin_config_next;
            secondary_port_clock_source_reg <= secondary_port_clock_source_next;
            secondary_port_input_source_reg <= secondary_port_input_source_next;
            pin_function_routing_reg <= pin_function_routing_next;
            rdata_reg <= rdata_next;
        end
    end

    // Source selectors; only the data-input selectors may take the data-out pin
    source_select #(.ALLOW_OUT_PIN(1'b0)) u_frame_select (
        .code(secondary_frame_source), .general_pin_one(general_pin_one),
        .general_pin_two(general_pin_two), .input_only_pin(input_only_pin),
        .out_pin(out_pin_in), .primary(primary_frame_in),
        .selected(frame_sel), .valid(frame_valid));
    source_select #(.ALLOW_OUT_PIN(1'b0)) u_bitclock_select (
        .code(secondary_bitclock_source), .general_pin_one(general_pin_one),
        .general_pin_two(general_pin_two), .input_only_pin(input_only_pin),
        .out_pin(out_pin_in), .primary(primary_bitclock_in),
        .selected(bitclock_sel), .valid(bitclock_valid));
    source_select #(.ALLOW_OUT_PIN(1'b1)) u_input_select (
        .code(secondary_input_source), .general_pin_one(general_pin_one),
        .general_pin_two(general_pin_two), .input_only_pin(input_only_pin),
        .out_pin(out_pin_in), .primary(primary_data_in),
        .selected(input_sel), .valid());
    source_select #(.ALLOW_OUT_PIN(1'b1)) u_input2_select (
        .code(secondary_input2_source), .general_pin_one(general_pin_one),
        .general_pin_two(general_pin_two), .input_only_pin(input_only_pin),
        .out_pin(out_pin_in), .primary(primary_data_in),
        .selected(input2_sel), .valid());
    // Power-down field is two bits, so it only reaches codes 0 to 3
    source_select #(.ALLOW_OUT_PIN(1'b0)) u_powerdown_select (
        .code({1'b0, pin_dac_powerdown_source}), .general_pin_one(general_pin_one),
        .general_pin_two(general_pin_two), .input_only_pin(input_only_pin),
        .out_pin(out_pin_in), .primary(1'b0),
        .selected(powerdown_sel), .valid());

    // Value that the data-out pin carries for its selected role
    always_comb begin
        pin_value = 1'b0;
        pin_driven = 1'b1;
        pin_as_input = 1'b0;
        case (out_pin_function)
            FN_INPUT: begin
                pin_driven = 1'b0;
                pin_as_input = 1'b1;
            end
            FN_GENERAL_OUTPUT: pin_value = out_pin_level;
            FN_INTERRUPT: pin_value = irq_in;
            FN_PDM_CLOCK: pin_value = pdm_clock_output;
            FN_PRIMARY_DATA: pin_value = primary_data_out;
            FN_PRIMARY_DATA2: pin_value = primary_data2_out;
            FN_SECONDARY_DATA: pin_value = secondary_data_out;
            FN_SECONDARY_DATA2: pin_value = secondary_data2_out;
            FN_SECONDARY_BITCLOCK: pin_value = secondary_bitclock_out;
            FN_SECONDARY_FRAME: pin_value = secondary_frame_out;
            FN_GENERAL_CLOCK: pin_value = general_clock_output;
            FN_MUXED_DATA: pin_value = muxed_data_out;
            FN_DAISY_OUT: pin_value = daisy_out;
            FN_LOOPBACK: pin_value = primary_data_in;
            default: pin_driven = 1'b0; // Disabled and reserved roles leave the pin floating
        endcase
    end

    // Drive style turns the pin value into enable and weak pulls
    always_comb begin
        out_next = pin_value;
        oe_next = 1'b0;
        pullup_next = 1'b0;
        pulldown_next = 1'b0;
        if (pin_driven) begin
            case (out_pin_drive_style)
                DRV_ACTIVE_BOTH: oe_next = 1'b1;
                DRV_WEAK_HIGH: begin
                    oe_next = !pin_value;
                    pullup_next = pin_value;
                end
                DRV_HIZ_HIGH: oe_next = !pin_value;
                DRV_WEAK_LOW: begin
                    oe_next = pin_value;
                    pulldown_next = !pin_value;
                end
                DRV_HIZ_LOW: oe_next = pin_value;
                default: oe_next = 1'b0; // Reserved styles are kept harmless as high impedance
            endcase
        end
    end

    // All outputs come from flops so the pins never see mux glitches
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out_reg <= 1'b0;
            oe_reg <= 1'b0;
            pullup_reg <= 1'b0;
            pulldown_reg <= 1'b0;
            as_input_reg <= 1'b0;
            primary_reg <= 1'b0;
            frame_reg <= 1'b0;
            bitclock_reg <= 1'b0;
            data_reg <= 1'b0;
            data2_reg <= 1'b0;
            enable_reg <= 1'b0;
            powerdown_reg <= 1'b0;
            power_limit_function_reg <= 1'b0;
            gain_reg <= 1'b0;
        end else if (clk_en) begin
            out_reg <= out_next;
            oe_reg <= oe_next;
            pullup_reg <= pullup_next;
            pulldown_reg <= pulldown_next;
            as_input_reg <= pin_as_input;
            primary_reg <= primary_input_enable & primary_data_in;
            frame_reg <= frame_sel;
            bitclock_reg <= bitclock_sel;
            data_reg <= input_sel;
            data2_reg <= input2_sel;
            enable_reg <= frame_valid & bitclock_valid & (secondary_frame_source != SRC_OFF)
                & (secondary_bitclock_source != SRC_OFF);
            powerdown_reg <= powerdown_sel | register_dac_powerdown;
            power_limit_function_reg <= power_limit_pin_route & general_pin_one;
            gain_reg <= gain_adjust_pin_route & general_pin_one;
        end
    end

    assign reg_rdata = rdata_reg;
    assign out_pin_out = out_reg;
    assign out_pin_oe = oe_reg;
    assign out_pin_pullup = pullup_reg;
    assign out_pin_pulldown = pulldown_reg;
    assign out_pin_as_input = as_input_reg;
    assign primary_data = primary_reg;
    assign secondary_frame = frame_reg;
    assign secondary_bitclock = bitclock_reg;
    assign secondary_data = data_reg;
    assign secondary_data2 = data2_reg;
    assign secondary_port_enable = enable_reg;
    assign dac_powerdown = powerdown_reg;
    assign power_limit_function = power_limit_function_reg;
    assign gain_adjust_function = gain_reg;

    // Checks on the routing outputs
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_gpo_level_drive: assert property (clk_en && out_pin_function == FN_GENERAL_OUTPUT
        && out_pin_drive_style == DRV_ACTIVE_BOTH |=> out_pin_oe && out_pin_out == $past(out_pin_level))
        else $error("general output level not driven");
    a_pin_off_floats: assert property (clk_en && (out_pin_function == FN_DISABLED
        || out_pin_function == FN_INPUT) |=> !out_pin_oe && !out_pin_pullup && !out_pin_pulldown)
        else $error("disabled or input pin is driven");
    a_loopback_route: assert property (clk_en && out_pin_function == FN_LOOPBACK
        && out_pin_drive_style == DRV_ACTIVE_BOTH |=> out_pin_out == $past(primary_data_in) && out_pin_oe)
        else $error("loopback not routed");
    a_reserved_fn_float: assert property (clk_en && out_pin_function == FN_RESERVED |=> !out_pin_oe)
        else $error("reserved function drives pin");
    a_weak_high_style: assert property (clk_en && out_pin_function == FN_GENERAL_OUTPUT
        && out_pin_drive_style == DRV_WEAK_HIGH |=> out_pin_oe == !$past(out_pin_level)
        && out_pin_pullup == $past(out_pin_level))
        else $error("weak high style wrong");
    a_primary_gate: assert property (clk_en |=> primary_data ==
        ($past(primary_input_enable) && $past(primary_data_in)))
        else $error("primary data gate wrong");
    a_frame_reserved_off: assert property (clk_en && secondary_frame_source == SRC_OUT_PIN
        |=> !secondary_frame && !secondary_port_enable)
        else $error("reserved frame source active");
    a_frame_primary: assert property (clk_en && secondary_frame_source == SRC_PRIMARY
        |=> secondary_frame == $past(primary_frame_in))
        else $error("frame source not primary");
    a_bitclock_pin: assert property (clk_en && secondary_bitclock_source == SRC_GENERAL_PIN_TWO
        |=> secondary_bitclock == $past(general_pin_two))
        else $error("bit clock source wrong");
    a_input_out_pin: assert property (clk_en && secondary_input_source == SRC_OUT_PIN
        |=> secondary_data == $past(out_pin_in))
        else $error("data input not from out pin");
    a_input2_primary: assert property (clk_en && secondary_input2_source == SRC_PRIMARY
        |=> secondary_data2 == $past(primary_data_in))
        else $error("second data input wrong");
    a_powerdown_or: assert property (clk_en && pin_dac_powerdown_source == 2'h3
        |=> dac_powerdown == ($past(input_only_pin) || $past(register_dac_powerdown)))
        else $error("power down combine wrong");
    a_limit_gain_route: assert property (clk_en |=> power_limit_function ==
        ($past(power_limit_pin_route) && $past(general_pin_one)) && gain_adjust_function ==
        ($past(gain_adjust_pin_route) && $past(general_pin_one)))
        else $error("limit or gain route wrong");

    c_general_output: cover property (clk_en && out_pin_function == FN_GENERAL_OUTPUT ##1 out_pin_oe);
    c_secondary_on: cover property (secondary_port_enable);
    c_loopback: cover property (clk_en && out_pin_function == FN_LOOPBACK);
    c_powerdown: cover property (dac_powerdown && !$past(register_dac_powerdown));
endmodule : audio_port_pin_routing

// ---- verification/pin_side_model.sv ----
// Board side of the data-out pin: resolves its level from drive, pulls and float
`timescale 1ns/10ps
module pin_side_model (
    input wire logic sys_clk,
    input wire logic drive,
    input wire logic oe,
    input wire logic pull_high,
    input wire logic pull_low,
    output logic pin_level
);
    logic flip = 1'b0;
    // A floating pin must not look settled, so it toggles every cycle
    always @(posedge sys_clk) flip <= ~flip;
    assign pin_level = oe ? drive : pull_high ? 1'b1 : pull_low ? 1'b0 : flip;
endmodule : pin_side_model

// ---- verification/audio_port_pin_routing_tb_top.sv ----
// Self-checking bench for the audio port pin routing block
`timescale 1ns/10ps
module audio_port_pin_routing_tb_top;
    import pin_routing_pkg::*;
    typedef struct packed {logic [7:0] r10; logic [7:0] r11; logic [7:0] r12; logic [7:0] r14;
        logic [16:0] s; logic dreq; logic [13:0] e;} row_t;
    // Rows: register images, sources, register power-down, expected pin and routing outputs
    row_t rows [3] = '{'{8'h21, 8'h94, 8'h8c, 8'h0b, 17'h1_4001, 1'b1, 14'h119f},
        '{8'h29, 8'h5a, 8'hb4, 8'h04, 17'h1_0005, 1'b0, 14'h30bc},
        '{8'hf2, 8'hcc, 8'hdc, 8'h0c, 17'h1_ffff, 1'b1, 14'h0104}};
    logic [7:0] radr [4] = '{8'h11, 8'h12, 8'h14, 8'h13};
    logic [7:0] rrst [4] = '{8'h80, 8'h00, 8'h00, 8'h00};
    logic [7:0] wimg [4] = '{8'hff, 8'hff, 8'h0f, 8'hff};
    logic [7:0] rmsk [4] = '{8'hfe, 8'hfc, 8'h0f, 8'h00};
    logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, dac_req = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
    logic [16:0] src = 17'h0_0020;
    logic [16:0] e4;
    logic out_pin_out, out_pin_oe, pu, pd, as_in, pin_in, e_oe;
    wire [8:0] route;
    int fail_count = 0, check_count = 0;
    wire [13:0] seen = {out_pin_out & out_pin_oe, out_pin_oe, pu, pd, as_in, route};
    // Free-running system clock
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    audio_port_pin_routing dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .general_pin_one(src[16]), .general_pin_two(src[15]), .input_only_pin(src[14]), .out_pin_in(pin_in),
        .out_pin_out(out_pin_out), .out_pin_oe(out_pin_oe), .out_pin_pullup(pu), .out_pin_pulldown(pd),
        .out_pin_as_input(as_in), .irq_in(src[3]), .pdm_clock_output(src[4]), .primary_data_out(src[5]),
        .primary_data2_out(src[6]), .secondary_data_out(src[7]), .secondary_data2_out(src[8]),
        .secondary_bitclock_out(src[9]), .secondary_frame_out(src[10]), .general_clock_output(src[11]),
        .muxed_data_out(src[12]), .daisy_out(src[13]), .primary_frame_in(src[2]), .primary_bitclock_in(src[1]),
        .primary_data_in(src[0]), .register_dac_powerdown(dac_req), .primary_data(route[8]),
        .secondary_frame(route[7]), .secondary_bitclock(route[6]), .secondary_data(route[5]),
        .secondary_data2(route[4]), .secondary_port_enable(route[3]), .dac_powerdown(route[2]),
        .power_limit_function(route[1]), .gain_adjust_function(route[0]));
    pin_side_model pm (.sys_clk(sys_clk), .drive(out_pin_out), .oe(out_pin_oe), .pull_high(pu), .pull_low(pd),
        .pin_level(pin_in));
    // Callers pass the value seen first, then the value the rules expect
    task automatic chk(input string what, input logic [16:0] got, input logic [16:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd
    // Outputs lag the register by one edge; three edges leave margin
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic dflt;
        settle();
        chk("default pin", 17'({out_pin_oe, pu, pd}), 17'h0_0002);
        rd(8'h10);
        chk("reset 0x10", 17'(rd_val), 17'h0_0052);
        $display("test defaults done");
    endtask : dflt
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // Main sequence: reset, register map, table rows, function and drive-style sweeps, then clock enable and a second reset
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        dflt();
        foreach (radr[i]) begin
            rd(radr[i]);
            chk("reset value", 17'(rd_val), 17'(rrst[i]));
            wr(radr[i], wimg[i]);
            rd(radr[i]);
            chk("masked readback", 17'(rd_val), 17'(rmsk[i]));
        end
        $display("test register map done");
        foreach (rows[i]) begin
            @(posedge sys_clk);
            src <= rows[i].s;
            dac_req <= rows[i].dreq;
            wr(8'h10, rows[i].r10);
            wr(8'h11, rows[i].r11);
            wr(8'h12, rows[i].r12);
            wr(8'h14, rows[i].r14);
            settle();
            chk("routing row", 17'(seen), 17'(rows[i].e));
            $display("test row %0d done", i);
        end
        // Function codes 0 to 14 with push-pull drive: one source is high, the selected one for codes 3 to 14
        for (int k = 0; k < 15; k++) begin
            @(posedge sys_clk);
            src <= 17'h0_0001 << ((k == 14) ? 0 : k);
            wr(8'h10, {4'(k), 4'h1});
            settle();
            chk("pin function", 17'({out_pin_out & out_pin_oe, as_in}), 17'({k > 2, k == 1}));
        end
        $display("test functions done");
        // Drive styles 0 to 5 only; the two reserved codes are never written
        for (int s = 0; s < 6; s++) begin
            for (int v = 0; v < 2; v++) begin
                wr(8'h10, {4'h2, 1'(v), 3'(s)});
                settle();
                e_oe = (s == 1) || (v == 0 && (s == 2 || s == 3)) || (v == 1 && s > 3);
                e4 = 17'({e_oe, s == 2 && v == 1, s == 4 && v == 0, e_oe && v == 1});
                chk("drive style", 17'({out_pin_oe, pu, pd, out_pin_out & out_pin_oe}), e4);
            end
        end
        $display("test styles done");
        // Clock enable low freezes registers and pins, so this write is lost
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(8'h10, 8'h20);
        settle();
        chk("frozen pin", 17'({out_pin_oe, out_pin_out}), 17'h0_0003);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rd(8'h10);
        chk("frozen write", 17'(rd_val), 17'h0_002d);
        $display("test clock enable done");
        // Second reset in mid-run must restore the defaults
        @(posedge sys_clk);
        src <= 17'h0_0020;
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        dflt();
        complete_run();
    end
    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        complete_run();
    end
endmodule : audio_port_pin_routing_tb_top
